// ### pwc_pkg.sv
// constants and helper functions for the periodic wakeup counter
package pwc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned DIV_W  = 18;

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_STATUS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_COUNT       = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_LIMIT       = 8'h08;

  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned SRC_HI   = 6;
  localparam int unsigned SRC_LO   = 5;
  localparam int unsigned IE_BIT   = 4;
  localparam int unsigned PS_HI    = 3;
  localparam int unsigned PS_LO    = 0;

  localparam logic [1:0]       SRC_RESET   = 2'h0;
  localparam logic [3:0]       PS_OFF      = 4'h0;
  localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_ONE   = 8'h01;
  localparam logic [CNT_W-1:0] LIMIT_RESET = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE     = 18'h00001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // divide ratio; zero means the prescaler is off
  function automatic logic [DIV_W-1:0] pwc_div_ratio(
    input logic       hi_range,
    input logic [3:0] code
  );
    logic [DIV_W-1:0] r;
    r = 18'h00000;
    case ({hi_range, code})
      5'h01: r = 18'h00008;
      5'h02: r = 18'h00020;
      5'h03: r = 18'h00040;
      5'h04: r = 18'h00080;
      5'h05: r = 18'h00100;
      5'h06: r = 18'h00200;
      5'h07: r = 18'h00400;
      5'h08: r = 18'h00001;
      5'h09: r = 18'h00002;
      5'h0a: r = 18'h00004;
      5'h0b: r = 18'h0000a;
      5'h0c: r = 18'h00010;
      5'h0d: r = 18'h00064;
      5'h0e: r = 18'h001f4;
      5'h0f: r = 18'h003e8;
      5'h11: r = 18'h00400;
      5'h12: r = 18'h00800;
      5'h13: r = 18'h01000;
      5'h14: r = 18'h02000;
      5'h15: r = 18'h04000;
      5'h16: r = 18'h08000;
      5'h17: r = 18'h10000;
      5'h18: r = 18'h003e8;
      5'h19: r = 18'h007d0;
      5'h1a: r = 18'h01388;
      5'h1b: r = 18'h02710;
      5'h1c: r = 18'h04e20;
      5'h1d: r = 18'h0c350;
      5'h1e: r = 18'h186a0;
      5'h1f: r = 18'h30d40;
      default: r = 18'h00000;
    endcase
    return r;
  endfunction : pwc_div_ratio

  function automatic logic pwc_addr_hit(input logic [AXI_AW-1:0] a);
    return (a == OFS_STATUS_CTRL) || (a == OFS_COUNT) ||
           (a == OFS_LIMIT);
  endfunction : pwc_addr_hit

endpackage : pwc_pkg

// ### pwc_axil_slave.sv
// axi4-lite slave front end for the periodic wakeup counter
`timescale 1ns/100ps
`default_nettype none
module pwc_axil_slave (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [pwc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [pwc_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [pwc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [pwc_pkg::AXI_DW-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           wr_en,
  output logic [pwc_pkg::AXI_AW-1:0]     wr_addr,
  output logic [pwc_pkg::AXI_DW-1:0]     wr_data,
  output logic [3:0]                     wr_strb,
  output logic [pwc_pkg::AXI_AW-1:0]     rd_addr,
  input  wire logic [pwc_pkg::AXI_DW-1:0] rd_data
);
  import pwc_pkg::*;

  logic              aw_got_q;
  logic              w_got_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [AXI_DW-1:0] rdata_q;
  logic              wr_fire;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // address and data are latched independently, in either order
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;
  assign wr_en         = wr_fire && pwc_addr_hit(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      wr_addr  <= '0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      wr_addr  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= pwc_addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign rd_addr       = s_axi_araddr;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= pwc_addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= pwc_addr_hit(s_axi_araddr) ? rd_data : '0;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule : pwc_axil_slave
`default_nettype wire

// ### pwc_prescaler.sv
// source synchronisers, source select and programmable prescaler
`timescale 1ns/100ps
`default_nettype none
module pwc_prescaler #(
  parameter int unsigned DIV_W = pwc_pkg::DIV_W
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       lowpower_1khz_osc,
  input  wire logic       external_ref_clock,
  input  wire logic       internal_ref_clock,
  input  wire logic [1:0] source_select,
  input  wire logic [3:0] divider_select,
  input  wire logic       deep_stop,
  input  wire logic       freeze,
  input  wire logic       clear,
  output logic            tick
);
  import pwc_pkg::*;

  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic [2:0]       seen_q;
  logic [2:0]       rise;
  logic             src_edge;
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] cnt_q;
  logic             at_end;

  // ---------------------------------------------------------------
  // synchronise and edge-detect the three sources
  // ---------------------------------------------------------------
  // sources are far slower than aclk, so sampling is lossless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      seen_q  <= 3'h0;
    end else begin
      sync1_q <= {internal_ref_clock, external_ref_clock,
                  lowpower_1khz_osc};
      sync2_q <= sync1_q;
      seen_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~seen_q;

  // reference sources are unavailable in the deepest stop level
  always_comb begin
    src_edge = 1'b0;
    if (source_select[1]) begin
      src_edge = rise[2] && !deep_stop;
    end else if (source_select[0]) begin
      src_edge = rise[1] && !deep_stop;
    end else begin
      src_edge = rise[0];
    end
  end

  // ---------------------------------------------------------------
  // divider chain
  // ---------------------------------------------------------------
  assign div    = pwc_div_ratio(source_select[0], divider_select);
  assign at_end = (cnt_q == DIV_W'(div - DIV_ONE));
  assign tick   = src_edge && at_end && (divider_select != PS_OFF) &&
                  !freeze && !clear;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= '0;
    end else if (src_edge && !freeze &&
                 divider_select != PS_OFF) begin
      cnt_q <= at_end ? '0 : DIV_W'(cnt_q + DIV_ONE);
    end
  end

endmodule : pwc_prescaler
`default_nettype wire

// ### pwc_periodic_wakeup.sv
// periodic wakeup counter: registers, match counter and checks
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - eight-bit up-counter compared against programmable limit
// - source select picks low-power, external or internal
// - changing source select clears prescaler and count
// - changing divider select clears prescaler and count
// - low-range divide ratios, code zero is off
// - high-range divide ratios, code zero is off
// - match sets flag; writing one clears it
// - reset clears flag, source, enable, divider select
// - request raised while flag and enable both set
// - count read-only; cleared by reset, limit writes and selection changes
// - counter keeps running in wait mode
// - counter keeps running in both stop levels
// - reference sources unavailable in deepest stop
// - debug halt freezes counting, resumes from value
// - at limit count wraps to zero, flag set
// - zero limit sets flag every prescaler tick
// - limit write clears prescaler and count; resets zero
module pwc_periodic_wakeup (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [pwc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [pwc_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [pwc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [pwc_pkg::AXI_DW-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      lowpower_1khz_osc,
  input  wire logic                      external_ref_clock,
  input  wire logic                      internal_ref_clock,
  input  wire logic                      deep_stop,
  input  wire logic                      debug_halt,
  output logic                           match_irq
);
  import pwc_pkg::*;

  // ---------------------------------------------------------------
  // state and wiring
  // ---------------------------------------------------------------
  logic              match_irq_flag_q;
  logic [1:0]        source_select_q;
  logic              match_irq_enable_q;
  logic [3:0]        divider_select_q;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  limit_q;

  logic              wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic [AXI_AW-1:0] rd_addr;
  logic [AXI_DW-1:0] rd_data;

  logic              wr_ctrl;
  logic              wr_limit;
  logic              sel_change;
  logic              presc_clear;
  logic              tick;
  logic              count_wrap;

  // ---------------------------------------------------------------
  // bus slave and prescaler
  // ---------------------------------------------------------------
  pwc_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  pwc_prescaler #(
    .DIV_W (DIV_W)
  ) u_presc (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .lowpower_1khz_osc  (lowpower_1khz_osc),
    .external_ref_clock (external_ref_clock),
    .internal_ref_clock (internal_ref_clock),
    .source_select      (source_select_q),
    .divider_select     (divider_select_q),
    .deep_stop          (deep_stop),
    .freeze             (debug_halt),
    .clear              (presc_clear),
    .tick               (tick)
  );

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // only byte lane 0 carries register bits
  assign wr_ctrl  = wr_en && wr_addr == OFS_STATUS_CTRL && wr_strb[0];
  assign wr_limit = wr_en && wr_addr == OFS_LIMIT && wr_strb[0];

  // rewriting the same selection must not restart the period
  assign sel_change = wr_ctrl &&
    (wr_data[SRC_HI:SRC_LO] != source_select_q ||
     wr_data[PS_HI:PS_LO] != divider_select_q);
  assign presc_clear = sel_change || wr_limit;

  assign count_wrap = tick && count_q == limit_q;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_select_q    <= SRC_RESET;
      match_irq_enable_q <= 1'b0;
      divider_select_q   <= PS_OFF;
    end else if (wr_ctrl) begin
      source_select_q    <= wr_data[SRC_HI:SRC_LO];
      match_irq_enable_q <= wr_data[IE_BIT];
      divider_select_q   <= wr_data[PS_HI:PS_LO];
    end
  end

  // a match in the clearing cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_irq_flag_q <= 1'b0;
    end else if (count_wrap) begin
      match_irq_flag_q <= 1'b1;
    end else if (wr_ctrl && wr_data[FLAG_BIT]) begin
      match_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_q <= LIMIT_RESET;
    end else if (wr_limit) begin
      limit_q <= wr_data[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // match counter
  // ---------------------------------------------------------------
  // besides debug_halt, only deep_stop gates counting, for reference sources; wait and stop run on
  always_ff @(posedge aclk) begin
    if (!aresetn || presc_clear) begin
      count_q <= COUNT_RESET;
    end else if (count_wrap) begin
      count_q <= COUNT_RESET;
    end else if (tick) begin
      count_q <= CNT_W'(count_q + COUNT_ONE);
    end
  end

  // request doubles as the wake-up from wait and stop
  assign match_irq = match_irq_flag_q && match_irq_enable_q;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // count has no write path at all, so writes to it are dropped
  always_comb begin
    rd_data = '0;
    case (rd_addr)
      OFS_STATUS_CTRL: begin
        rd_data[FLAG_BIT]      = match_irq_flag_q;
        rd_data[SRC_HI:SRC_LO] = source_select_q;
        rd_data[IE_BIT]        = match_irq_enable_q;
        rd_data[PS_HI:PS_LO]   = divider_select_q;
      end
      OFS_COUNT: rd_data[CNT_W-1:0] = count_q;
      OFS_LIMIT: rd_data[CNT_W-1:0] = limit_q;
      default:   rd_data = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_wrap_sets_flag: assert property (
    count_wrap && !presc_clear |=> count_q == COUNT_RESET &&
      match_irq_flag_q)
    else $error("count did not wrap with flag set at limit");

  chk_count_steps: assert property (
    tick && !count_wrap && !presc_clear |=>
      count_q == CNT_W'($past(count_q) + COUNT_ONE))
    else $error("count did not advance by one on tick");

  chk_flag_w1c: assert property (
    wr_ctrl && wr_data[FLAG_BIT] && !count_wrap |=> !match_irq_flag_q)
    else $error("writing one did not clear the flag");

  chk_flag_w0_keeps: assert property (
    match_irq_flag_q && !(wr_ctrl && wr_data[FLAG_BIT])
      |=> match_irq_flag_q)
    else $error("flag dropped without a clearing write");

  chk_set_beats_clear: assert property (
    count_wrap && wr_ctrl && wr_data[FLAG_BIT] |=> match_irq_flag_q)
    else $error("coincident match lost to flag clear");

  chk_limit_clears: assert property (
    wr_limit |=> count_q == COUNT_RESET &&
      limit_q == $past(wr_data[CNT_W-1:0]))
    else $error("limit write did not clear count");

  // a source edge right after the clear may tick legally at divide-by-1
  chk_select_clears: assert property (
    sel_change |=> count_q == COUNT_RESET &&
      divider_select_q == $past(wr_data[PS_HI:PS_LO]) &&
      source_select_q == $past(wr_data[SRC_HI:SRC_LO]))
    else $error("selection change did not clear count");

  chk_debug_freeze: assert property (
    debug_halt && !presc_clear |-> !tick ##1 $stable(count_q))
    else $error("count moved during debug halt");

  chk_off_no_tick: assert property (
    divider_select_q == PS_OFF |-> !tick)
    else $error("prescaler ticked while off");

  chk_zero_limit: assert property (
    tick && limit_q == LIMIT_RESET && !presc_clear |=> match_irq_flag_q)
    else $error("zero limit did not set flag on tick");

  chk_irq_level: assert property (
    count_wrap && match_irq_enable_q && !wr_ctrl |=> match_irq)
    else $error("request not raised after match with enable set");

  // the count may only move on a tick or a clear
  chk_count_ro: assert property (
    wr_en && wr_addr == OFS_COUNT && !tick |=> $stable(count_q))
    else $error("write to the count register moved the count");

  chk_same_sel_keeps: assert property (
    wr_ctrl && !sel_change && !tick |=> $stable(count_q))
    else $error("unchanged selection restarted the count");

  chk_deep_stop_ref: assert property (
    deep_stop && source_select_q != SRC_RESET |-> !tick)
    else $error("reference source ticked in deepest stop");

  chk_count_bound: assert property (
    count_q <= limit_q)
    else $error("count ran past the match limit");

  chk_off_holds: assert property (
    divider_select_q == PS_OFF && !presc_clear |=> $stable(count_q))
    else $error("count moved while the prescaler was off");

  chk_halt_no_flag: assert property (
    debug_halt && !match_irq_flag_q |=> !match_irq_flag_q)
    else $error("flag set during debug halt");

  chk_reset_values: assert property (disable iff (1'b0)
    !aresetn |=> !match_irq_flag_q && source_select_q == SRC_RESET &&
      !match_irq_enable_q && divider_select_q == PS_OFF &&
      count_q == COUNT_RESET && limit_q == LIMIT_RESET)
    else $error("registers not cleared by reset");

  cov_wrap:        cover property (count_wrap && limit_q != LIMIT_RESET);
  cov_flag_clear:  cover property (match_irq_flag_q && wr_ctrl &&
                                   wr_data[FLAG_BIT]);
  cov_irq_raised:  cover property ($rose(match_irq));
  cov_debug_hold:  cover property (debug_halt && count_q != COUNT_RESET);
  // the coincident case needs a deliberately timed source edge
  cov_set_wins:    cover property (count_wrap && wr_ctrl &&
                                   wr_data[FLAG_BIT]);

endmodule : pwc_periodic_wakeup
`default_nettype wire

// ### pwc_periodic_wakeup_tb.sv
// self-checking testbench for the periodic wakeup counter
`timescale 1ns/100ps
`default_nettype none
module pwc_periodic_wakeup_tb;
  import pwc_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [AXI_DW-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [2:0]        srcs = 3'h0;
  logic              deep_stop = 0, debug_halt = 0, match_irq;
  int                fails = 0, checks_done = 0;

  always #2 aclk = ~aclk;

  pwc_periodic_wakeup dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lowpower_1khz_osc(srcs[0]), .external_ref_clock(srcs[1]),
    .internal_ref_clock(srcs[2]), .deep_stop(deep_stop),
    .debug_halt(debug_halt), .match_irq(match_irq)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] resp = RESP_OKAY);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk({30'h0, bresp}, {30'h0, resp});
    // idle edge so the next call never re-raises in this time step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] resp = RESP_OKAY);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, resp});
    @(posedge aclk);
  endtask : rd

  // slow source pulses; trailing low time covers synchroniser delay
  task automatic pulse(input int w, input int n);
    repeat (n) begin
      srcs[w] <= 1'b1;
      repeat (6) @(posedge aclk);
      srcs[w] <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask : pulse

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_STATUS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_LIMIT, 32'h0);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    wr(OFS_COUNT, 32'h55);
    rd(OFS_COUNT, 32'h0);
    $display("test reset and access done");
    wr(OFS_LIMIT, 32'h3);
    wr(OFS_STATUS_CTRL, 32'h18);
    pulse(0, 3);
    rd(OFS_COUNT, 32'h3);
    chk({31'h0, match_irq}, 32'h0);
    pulse(0, 1);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_STATUS_CTRL, 32'h98);
    chk({31'h0, match_irq}, 32'h1);
    wr(OFS_STATUS_CTRL, 32'h18);
    rd(OFS_STATUS_CTRL, 32'h98);
    wr(OFS_STATUS_CTRL, 32'h98);
    rd(OFS_STATUS_CTRL, 32'h18);
    chk({31'h0, match_irq}, 32'h0);
    $display("test match and flag done");
    // frozen edges must not be counted
    pulse(0, 2);
    debug_halt <= 1'b1;
    pulse(0, 2);
    debug_halt <= 1'b0;
    rd(OFS_COUNT, 32'h2);
    pulse(0, 1);
    rd(OFS_COUNT, 32'h3);
    wr(OFS_STATUS_CTRL, 32'h19);
    rd(OFS_COUNT, 32'h0);
    pulse(0, 2);
    rd(OFS_COUNT, 32'h1);
    $display("test halt and divider done");
    wr(OFS_STATUS_CTRL, 32'h48);
    rd(OFS_COUNT, 32'h0);
    pulse(0, 2);
    rd(OFS_COUNT, 32'h0);
    pulse(2, 2);
    rd(OFS_COUNT, 32'h2);
    deep_stop <= 1'b1;
    pulse(2, 2);
    deep_stop <= 1'b0;
    rd(OFS_COUNT, 32'h2);
    wr(OFS_LIMIT, 32'h0);
    rd(OFS_COUNT, 32'h0);
    pulse(2, 1);
    rd(OFS_STATUS_CTRL, 32'hc8);
    chk({31'h0, match_irq}, 32'h0);
    $display("test source and zero limit done");
    // source edge lands in the cycle of the clearing write
    srcs[2] <= 1'b1;
    @(posedge aclk);
    wr(OFS_STATUS_CTRL, 32'hc8);
    srcs[2] <= 1'b0;
    rd(OFS_STATUS_CTRL, 32'hc8);
    wr(OFS_STATUS_CTRL, 32'hc8);
    rd(OFS_STATUS_CTRL, 32'h48);
    wr(OFS_STATUS_CTRL, 32'h28);
    pulse(1, 999);
    rd(OFS_STATUS_CTRL, 32'h28);
    pulse(1, 1);
    rd(OFS_STATUS_CTRL, 32'ha8);
    wr(OFS_STATUS_CTRL, 32'ha0);
    pulse(1, 2);
    rd(OFS_STATUS_CTRL, 32'h20);
    $display("test set-wins and external source done");
    wr(OFS_LIMIT, 32'h5);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_STATUS_CTRL, 32'h0);
    rd(OFS_LIMIT, 32'h0);
    $display("test mid-run reset done");
    wrap_up();
  end

  // watchdog: the full sequence needs about 12400 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    wrap_up();
  end
endmodule : pwc_periodic_wakeup_tb
`default_nettype wire
